// ==== common/charger_setting_defs.svh ====
// offsets, reset codes and setpoint scales of the charger settings
`ifndef CHARGER_SETTING_DEFS_SVH
`define CHARGER_SETTING_DEFS_SVH

// register indices; byte address is four times the index
`define CHARGE_CURRENT_IDX      8'h0f
`define SUPPLY_LIMIT_IDX        8'h10
`define THERMAL_REDUCTION_IDX   8'h11
`define THERMAL_THRESHOLD_IDX   8'h12

// reset codes
`define FAST_CHARGE_RST         4'h6
`define WEAK_CURRENT_RST        2'h1
`define RECONNECT_RST           3'h3
`define INPUT_LIMIT_RST         2'h0
`define VOLT_REDUCTION_RST      2'h2
`define CURR_REDUCTION_RST      2'h0
`define COLD_THRESHOLD_RST      3'h5
`define HOT_THRESHOLD_RST       3'h3
`define CHILLY_SELECT_RST       1'h0
`define WARM_SELECT_RST         1'h0

// setpoint scales: mA, mV; thresholds in mV
`define FAST_CHARGE_BASE_MA     16'h0190
`define FAST_CHARGE_STEP_MA     16'h0064
`define WEAK_STEP_MA            16'h0064
`define RECONNECT_BASE_MV       16'h0c1c
`define RECONNECT_STEP_MV       16'h0064
`define VOLT_RED_STEP_MV        16'h0064
`define CURR_RED_BASE_MA        16'h0190
`define CURR_RED_STEP_MA        16'h0064
`define COLD_AT_RST_MV          16'h06bd
`define HOT_AT_RST_MV           16'h020d
`define THRESHOLD_STEP_MV       16'h0092
`define CHILLY_OFFSET_0_MV      16'h0092
`define CHILLY_OFFSET_1_MV      16'h00db
`define WARM_OFFSET_0_MV        16'h0092
`define WARM_OFFSET_1_MV        16'h00db

`endif

// ==== common/charger_setting_pkg.sv ====
// types shared by the charger setting register bank
package charger_setting_pkg;

    typedef struct packed {
        logic [3:0] fast_charge_current;
        logic [1:0] weak_battery_current;
        logic [2:0] reconnect_threshold;
        logic [1:0] input_current_limit;
        logic [1:0] thermal_voltage_reduction;
        logic [1:0] thermal_current_reduction;
        logic [2:0] cold_threshold;
        logic [2:0] hot_threshold;
        logic       chilly_threshold_select;
        logic       warm_threshold_select;
    } setting_fields_s;

    typedef struct packed {
        logic [15:0] fast_charge_ma;
        logic [15:0] weak_charge_ma;
        logic [15:0] reconnect_mv;
        logic [15:0] input_limit_ma;
        logic [15:0] voltage_reduction_mv;
        logic [15:0] reduced_current_ma;
        logic [15:0] cold_threshold_mv;
        logic [15:0] hot_threshold_mv;
        logic [15:0] chilly_offset_mv;
        logic [15:0] warm_offset_mv;
    } setpoints_s;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b00,
        WR_RESP = 2'b01
    } write_state_e;

endpackage

// ==== core/setpoint_decoder.sv ====
// decodes the setting fields into analog loop setpoints
`include "charger_setting_defs.svh"

module setpoint_decoder (
    input  wire charger_setting_pkg::setting_fields_s fields,
    output charger_setting_pkg::setpoints_s           setpoints
);
    import charger_setting_pkg::*;

    // ===========================================================
    // fixed tables
    // ===========================================================
    wire [15:0] input_limit_table [4];
    assign input_limit_table[0] = 16'h0064;
    assign input_limit_table[1] = 16'h01f4;
    assign input_limit_table[2] = 16'h0384;
    assign input_limit_table[3] = 16'h05dc;

    // ===========================================================
    // linear setpoints, input limit table lookup and offset selects
    // ===========================================================
    // linear fast charge
    assign setpoints.fast_charge_ma = `FAST_CHARGE_BASE_MA
        + 16'(`FAST_CHARGE_STEP_MA * {12'h000, fields.fast_charge_current});
    assign setpoints.weak_charge_ma = 16'(`WEAK_STEP_MA * {14'h0000, fields.weak_battery_current});
    assign setpoints.reconnect_mv = `RECONNECT_BASE_MV
        + 16'(`RECONNECT_STEP_MV * {13'h0000, fields.reconnect_threshold});
    assign setpoints.input_limit_ma = input_limit_table[fields.input_current_limit];
    assign setpoints.voltage_reduction_mv =
        16'(`VOLT_RED_STEP_MV * {14'h0000, fields.thermal_voltage_reduction});
    assign setpoints.reduced_current_ma = `CURR_RED_BASE_MA
        + 16'(`CURR_RED_STEP_MA * {14'h0000, fields.thermal_current_reduction});
    assign setpoints.cold_threshold_mv = 16'(`COLD_AT_RST_MV
        + `THRESHOLD_STEP_MV * {13'h0000, fields.cold_threshold}
        - `THRESHOLD_STEP_MV * {13'h0000, `COLD_THRESHOLD_RST});
    assign setpoints.hot_threshold_mv = 16'(`HOT_AT_RST_MV
        + `THRESHOLD_STEP_MV * {13'h0000, fields.hot_threshold}
        - `THRESHOLD_STEP_MV * {13'h0000, `HOT_THRESHOLD_RST});
    assign setpoints.chilly_offset_mv = fields.chilly_threshold_select ?
        `CHILLY_OFFSET_1_MV : `CHILLY_OFFSET_0_MV;
    assign setpoints.warm_offset_mv = fields.warm_threshold_select ?
        `WARM_OFFSET_1_MV : `WARM_OFFSET_0_MV;

endmodule

// ==== core/charger_setting_registers.sv ====
// charge setting register bank with AXI4-Lite slave and setpoint outputs
//
// Functional notes
// - fast charge current: 400 mA plus 100 mA per code, reset 0110
// - weak battery current: off, 100, 200, 300 mA; reset 01
// - reconnection threshold 3.1 V to 3.8 V in 0.1 V steps; reset 011
// - input limit 100, 500, 900, 1500 mA; reset 00
// - thermal voltage drop 0 to 300 mV in 100 mV steps; reset 10
// - thermal reduced current 400 to 700 mA; reset 00
// - cold threshold 1.725 V at code 101, 0.146 V per step
// - hot threshold 0.525 V at code 011, 0.146 V per step
// - chilly select adds 0.146 V or 0.219 V to nominal chilly; reset 0
// - warm select subtracts 0.146 V or 0.219 V from nominal warm; reset 0
`include "charger_setting_defs.svh"

module charger_setting_registers (
    input  wire logic                             aclk,
    input  wire logic                             aresetn,
    // axi4-lite slave
    input  wire logic [9:0]                       s_axi_awaddr,
    input  wire logic [2:0]                       s_axi_awprot,
    input  wire logic                             s_axi_awvalid,
    output logic                                  s_axi_awready,
    input  wire logic [31:0]                      s_axi_wdata,
    input  wire logic [3:0]                       s_axi_wstrb,
    input  wire logic                             s_axi_wvalid,
    output logic                                  s_axi_wready,
    output logic [1:0]                            s_axi_bresp,
    output logic                                  s_axi_bvalid,
    input  wire logic                             s_axi_bready,
    input  wire logic [9:0]                       s_axi_araddr,
    input  wire logic [2:0]                       s_axi_arprot,
    input  wire logic                             s_axi_arvalid,
    output logic                                  s_axi_arready,
    output logic [31:0]                           s_axi_rdata,
    output logic [1:0]                            s_axi_rresp,
    output logic                                  s_axi_rvalid,
    input  wire logic                             s_axi_rready,
    // device-level reset sources, from pins
    input  wire logic                             off_state,
    input  wire logic                             software_reset,
    input  wire logic                             boost_supply_mode,
    // setting outputs
    output charger_setting_pkg::setting_fields_s  fields,
    output charger_setting_pkg::setpoints_s       setpoints
);
    import charger_setting_pkg::*;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ===========================================================
    // decode function
    // ===========================================================
    function automatic logic [2:0] reg_select(input logic [9:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        if (addr[1:0] != 2'b00)
            reg_select = 3'd0;
        else if (idx == `CHARGE_CURRENT_IDX)
            reg_select = 3'd1;
        else if (idx == `SUPPLY_LIMIT_IDX)
            reg_select = 3'd2;
        else if (idx == `THERMAL_REDUCTION_IDX)
            reg_select = 3'd3;
        else if (idx == `THERMAL_THRESHOLD_IDX)
            reg_select = 3'd4;
        else
            reg_select = 3'd0;
    endfunction

    // ===========================================================
    // pin synchronisers
    // ===========================================================
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
        end else begin
            sync1_reg <= {off_state, software_reset, boost_supply_mode};
            sync2_reg <= sync1_reg;
        end
    end

    wire field_clear = !aresetn || (|sync2_reg);

    // ===========================================================
    // write channel
    // ===========================================================
    write_state_e wr_state_reg;
    write_state_e wr_state_next;
    logic         aw_held_reg;
    logic [9:0]   aw_addr_reg;
    logic         w_held_reg;
    logic [31:0]  w_data_reg;
    logic         w_strb0_reg;
    logic [1:0]   bresp_reg;

    wire aw_take  = s_axi_awvalid && !aw_held_reg && (wr_state_reg == WR_IDLE);
    wire w_take   = s_axi_wvalid && !w_held_reg && (wr_state_reg == WR_IDLE);
    wire aw_have  = aw_held_reg || aw_take;
    wire w_have   = w_held_reg || w_take;
    wire [9:0]  wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
    wire [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
    wire        wr_lane = w_held_reg ? w_strb0_reg : s_axi_wstrb[0];
    wire        wr_fire = (wr_state_reg == WR_IDLE) && aw_have && w_have;
    wire [2:0]  wr_sel  = reg_select(wr_addr);
    wire        wr_en   = wr_fire && wr_lane;

    assign s_axi_awready = (wr_state_reg == WR_IDLE) && !aw_held_reg;
    assign s_axi_wready  = (wr_state_reg == WR_IDLE) && !w_held_reg;
    assign s_axi_bvalid  = (wr_state_reg == WR_RESP);
    assign s_axi_bresp   = bresp_reg;

    always_comb begin
        case (wr_state_reg)
            WR_IDLE: wr_state_next = wr_fire ? WR_RESP : WR_IDLE;
            WR_RESP: wr_state_next = s_axi_bready ? WR_IDLE : WR_RESP;
            default: wr_state_next = WR_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_reg <= WR_IDLE;
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            aw_addr_reg  <= 10'h000;
            w_data_reg   <= 32'h0000_0000;
            w_strb0_reg  <= 1'b0;
            bresp_reg    <= RESP_OKAY;
        end else begin
            wr_state_reg <= wr_state_next;
            aw_held_reg  <= aw_have && !wr_fire;
            w_held_reg   <= w_have && !wr_fire;
            if (aw_take)
                aw_addr_reg <= s_axi_awaddr;
            if (w_take) begin
                w_data_reg  <= s_axi_wdata;
                w_strb0_reg <= s_axi_wstrb[0];
            end
            if (wr_fire)
                bresp_reg <= (wr_sel == 3'd0) ? RESP_SLVERR : RESP_OKAY;
        end
    end

    // ===========================================================
    // setting registers
    // ===========================================================
    setting_fields_s fields_reg;
    setting_fields_s fields_next;
    setting_fields_s fields_rst;

    assign fields_rst = '{
        fast_charge_current:       `FAST_CHARGE_RST,
        weak_battery_current:      `WEAK_CURRENT_RST,
        reconnect_threshold:       `RECONNECT_RST,
        input_current_limit:       `INPUT_LIMIT_RST,
        thermal_voltage_reduction: `VOLT_REDUCTION_RST,
        thermal_current_reduction: `CURR_REDUCTION_RST,
        cold_threshold:            `COLD_THRESHOLD_RST,
        hot_threshold:             `HOT_THRESHOLD_RST,
        chilly_threshold_select:   `CHILLY_SELECT_RST,
        warm_threshold_select:     `WARM_SELECT_RST
    };

    always_comb begin
        fields_next = fields_reg;
        if (wr_en) begin
            case (wr_sel)
                3'd1: fields_next.fast_charge_current = wr_data[3:0];
                3'd2: begin
                    fields_next.weak_battery_current = wr_data[6:5];
                    fields_next.reconnect_threshold  = wr_data[4:2];
                    fields_next.input_current_limit  = wr_data[1:0];
                end
                3'd3: begin
                    fields_next.thermal_voltage_reduction = wr_data[3:2];
                    fields_next.thermal_current_reduction = wr_data[1:0];
                end
                3'd4: begin
                    fields_next.cold_threshold          = wr_data[7:5];
                    fields_next.hot_threshold           = wr_data[4:2];
                    fields_next.chilly_threshold_select = wr_data[1];
                    fields_next.warm_threshold_select   = wr_data[0];
                end
                default: fields_next = fields_reg;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (field_clear)
            fields_reg <= fields_rst;
        else
            fields_reg <= fields_next;
    end

    assign fields = fields_reg;

    // ===========================================================
    // read channel
    // ===========================================================
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    wire [2:0] rd_sel  = reg_select(s_axi_araddr);
    wire       rd_take = s_axi_arvalid && !rvalid_reg;
    logic [7:0] rd_byte;

    always_comb begin
        case (rd_sel)
            3'd1: rd_byte = {4'h0, fields_reg.fast_charge_current};
            3'd2: rd_byte = {1'b0, fields_reg.weak_battery_current,
                             fields_reg.reconnect_threshold, fields_reg.input_current_limit};
            3'd3: rd_byte = {4'h0, fields_reg.thermal_voltage_reduction,
                             fields_reg.thermal_current_reduction};
            3'd4: rd_byte = {fields_reg.cold_threshold, fields_reg.hot_threshold,
                             fields_reg.chilly_threshold_select,
                             fields_reg.warm_threshold_select};
            default: rd_byte = 8'h00;
        endcase
    end

    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
        end else if (rd_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= {24'h00_0000, rd_byte};
            rresp_reg  <= (rd_sel == 3'd0) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ===========================================================
    // setpoint decoding
    // ===========================================================
    setpoints_s setpoints_comb;

    setpoint_decoder decoder (
        .fields    (fields_reg),
        .setpoints (setpoints_comb)
    );

    always_ff @(posedge aclk) begin
        setpoints <= setpoints_comb;
    end

endmodule

// ==== bench/charger_setting_monitor.sv ====
// assertion checker for the charger setting register bank
`include "charger_setting_defs.svh"
module charger_setting_monitor
    import charger_setting_pkg::*;
(
    input wire logic        aclk, aresetn,
    input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid, s_axi_rready,
    input wire logic        off_state, software_reset, boost_supply_mode,
    input wire charger_setting_pkg::setting_fields_s fields,
    input wire charger_setting_pkg::setpoints_s      setpoints
);
    localparam setting_fields_s RST_F = '{`FAST_CHARGE_RST, `WEAK_CURRENT_RST,
        `RECONNECT_RST, `INPUT_LIMIT_RST, `VOLT_REDUCTION_RST, `CURR_REDUCTION_RST,
        `COLD_THRESHOLD_RST, `HOT_THRESHOLD_RST, `CHILLY_SELECT_RST, `WARM_SELECT_RST};
    logic any_src;
    assign any_src = off_state | software_reset | boost_supply_mode;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ==========================================
    // field storage and decode
    a_reset_codes: assert property ($rose(aresetn) |-> fields == RST_F)
        else $error("fields not at reset codes");
    a_source_clear: assert property (any_src [*4] |-> fields == RST_F)
        else $error("reset source did not clear fields");
    a_fast_scale: assert property (setpoints.fast_charge_ma ==
        16'd400 + 16'd100 * $past(fields.fast_charge_current)) else $error("fast charge");
    a_weak_scale: assert property (setpoints.weak_charge_ma ==
        16'd100 * $past(fields.weak_battery_current)) else $error("weak current");
    a_reconnect_scale: assert property (setpoints.reconnect_mv ==
        16'd3100 + 16'd100 * $past(fields.reconnect_threshold)) else $error("reconnect");
    a_limit_table: assert property (setpoints.input_limit_ma ==
        16'd100 + 16'd400 * $past(fields.input_current_limit)
        + (($past(fields.input_current_limit) == 2'h3) ? 16'd200 : 16'd0))
        else $error("input limit");
    a_vred_scale: assert property (setpoints.voltage_reduction_mv ==
        16'd100 * $past(fields.thermal_voltage_reduction)) else $error("voltage drop");
    a_ired_scale: assert property (setpoints.reduced_current_ma ==
        16'd400 + 16'd100 * $past(fields.thermal_current_reduction)) else $error("reduced");
    a_cold_scale: assert property (setpoints.cold_threshold_mv ==
        16'd995 + 16'd146 * $past(fields.cold_threshold)) else $error("cold threshold");
    a_hot_scale: assert property (setpoints.hot_threshold_mv ==
        16'd87 + 16'd146 * $past(fields.hot_threshold)) else $error("hot threshold");
    a_chilly_offset: assert property (setpoints.chilly_offset_mv ==
        ($past(fields.chilly_threshold_select) ? 16'd219 : 16'd146)) else $error("chilly");
    a_warm_offset: assert property (setpoints.warm_offset_mv ==
        ($past(fields.warm_threshold_select) ? 16'd219 : 16'd146)) else $error("warm");

    // ==========================================
    // register bus
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_busy_refuse: assert property ((s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        and (s_axi_rvalid |-> !s_axi_arready)) else $error("request taken while busy");
    a_reserved_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("reserved read bits set");

    c_write: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0);
    c_error: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    c_clear: cover property (any_src [*4]);
endmodule

// ==== bench/tb_charger_setting_registers.sv ====
// self-checking bench for the charger setting register bank
`include "charger_setting_defs.svh"
module tb_charger_setting_registers
    import charger_setting_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam setting_fields_s RST_F = '{`FAST_CHARGE_RST, `WEAK_CURRENT_RST,
        `RECONNECT_RST, `INPUT_LIMIT_RST, `VOLT_REDUCTION_RST, `CURR_REDUCTION_RST,
        `COLD_THRESHOLD_RST, `HOT_THRESHOLD_RST, `CHILLY_SELECT_RST, `WARM_SELECT_RST};
    logic [7:0]  idx_tab [4] = '{`CHARGE_CURRENT_IDX, `SUPPLY_LIMIT_IDX,
        `THERMAL_REDUCTION_IDX, `THERMAL_THRESHOLD_IDX};
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [9:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  wstrb = '0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        off_state = 1'b0, software_reset = 1'b0, boost_supply_mode = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    setting_fields_s fields, model;
    setpoints_s  setpoints;
    int          num_errors = 0, total_checks = 0;

    charger_setting_registers uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .off_state(off_state), .software_reset(software_reset),
        .boost_supply_mode(boost_supply_mode), .fields(fields), .setpoints(setpoints));

    // ==========================================
    // compare and bus tasks
    task automatic check_word(string what, logic [31:0] exp, logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_resp(string what, logic [1:0] exp, logic [1:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_fields(string what, setting_fields_s exp, setting_fields_s got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic axi_write(logic [9:0] a, logic [31:0] d, logic [3:0] s,
                             output logic [1:0] r);
        logic aw_ok, w_ok, b_ok;
        int   n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= a[2];
        n = 0;
        b_ok = 1'b0;
        while (!b_ok && n < 100) begin
            @(negedge aclk);
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            b_ok = bvalid && bready;
            r = bresp;
            @(posedge aclk);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
            if (!b_ok) bready <= 1'b1;
            n++;
        end
        bready <= 1'b0;
        if (!b_ok) num_errors++;
    endtask
    task automatic axi_read(logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_ok, r_ok;
        int   n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= a[2];
        n = 0;
        r_ok = 1'b0;
        while (!r_ok && n < 100) begin
            @(negedge aclk);
            ar_ok = arvalid && arready;
            r_ok = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar_ok) arvalid <= 1'b0;
            if (!r_ok) rready <= 1'b1;
            n++;
        end
        rready <= 1'b0;
        if (!r_ok) num_errors++;
    endtask

    // ==========================================
    // expected register images
    function automatic logic [31:0] exp_word(logic [7:0] i, setting_fields_s f);
        case (i)
            `CHARGE_CURRENT_IDX: return {28'h0, f.fast_charge_current};
            `SUPPLY_LIMIT_IDX: return {25'h0, f.weak_battery_current,
                f.reconnect_threshold, f.input_current_limit};
            `THERMAL_REDUCTION_IDX: return {28'h0, f.thermal_voltage_reduction,
                f.thermal_current_reduction};
            `THERMAL_THRESHOLD_IDX: return {24'h0, f.cold_threshold, f.hot_threshold,
                f.chilly_threshold_select, f.warm_threshold_select};
            default: return 32'h0;
        endcase
    endfunction
    function automatic setting_fields_s put_word(logic [7:0] i, logic [31:0] d,
                                                 setting_fields_s f);
        case (i)
            `CHARGE_CURRENT_IDX: f.fast_charge_current = d[3:0];
            `SUPPLY_LIMIT_IDX: {f.weak_battery_current, f.reconnect_threshold,
                f.input_current_limit} = d[6:0];
            `THERMAL_REDUCTION_IDX: {f.thermal_voltage_reduction,
                f.thermal_current_reduction} = d[3:0];
            `THERMAL_THRESHOLD_IDX: {f.cold_threshold, f.hot_threshold,
                f.chilly_threshold_select, f.warm_threshold_select} = d[7:0];
            default: ;
        endcase
        return f;
    endfunction
    task automatic check_all();
        logic [31:0] d;
        logic [1:0]  r;
        for (int k = 0; k < 4; k++) begin
            axi_read({idx_tab[k], 2'b00}, d, r);
            check_word("readback", exp_word(idx_tab[k], model), d);
            check_resp("read resp", 2'h0, r);
        end
        check_fields("fields", model, fields);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ==========================================
    // clock, watchdog, sequence
    initial begin
        forever #5 aclk = ~aclk;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        summarize();
    end
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        void'($urandom(65));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        model = RST_F;
        check_all();
        // all ones, all zeros, then random words
        for (int n = 0; n < 48; n++) begin
            d = (n < 4) ? 32'hffffffff : (n < 8) ? 32'h0 : $urandom;
            axi_write({idx_tab[n % 4], 2'b00}, d, 4'hf, r);
            check_resp("write resp", 2'h0, r);
            model = put_word(idx_tab[n % 4], d, model);
            if (n % 4 == 3) check_all();
        end
        axi_write({idx_tab[0], 2'b00}, {28'h0, ~model.fast_charge_current}, 4'he, r);
        check_resp("strobe resp", 2'h0, r);
        axi_write(10'h04c, 32'hff, 4'hf, r);
        check_resp("unmapped write", 2'h2, r);
        axi_read(10'h04c, d, r);
        check_resp("unmapped read", 2'h2, r);
        check_word("unmapped data", 32'h0, d);
        axi_read(10'h03d, d, r);
        check_resp("unaligned read", 2'h2, r);
        check_all();
        for (int s = 0; s < 3; s++) begin
            axi_write({idx_tab[s], 2'b00}, 32'hff, 4'hf, r);
            off_state <= (s == 0);
            software_reset <= (s == 1);
            boost_supply_mode <= (s == 2);
            repeat (5) @(posedge aclk);
            model = RST_F;
            check_fields("source clear", model, fields);
            off_state <= 1'b0;
            software_reset <= 1'b0;
            boost_supply_mode <= 1'b0;
            repeat (4) @(posedge aclk);
            check_all();
        end
        axi_write({idx_tab[3], 2'b00}, 32'h0, 4'hf, r);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        check_all();
        summarize();
    end
endmodule

bind charger_setting_registers charger_setting_monitor mon (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rresp(s_axi_rresp),
    .off_state(off_state), .software_reset(software_reset),
    .boost_supply_mode(boost_supply_mode), .fields(fields), .setpoints(setpoints));
